// file: i2ccb_config.sv
// Purpose: I2C config control bits with APB registers and interrupt
// Assumes: Single core clock, open-drain SCL, SDA only observed
// Notes:   Pins pass three flops; a level counts when stages 2 and 3 agree
`timescale 1ns/1ps
`include "i2ccb_map.svh"

// What this block does
// [R01] While the stretch bit is set the block holds SCL low, else only the low half of the master clock pulls it low.
// [R02] The transmit request interrupt is suppressed by a 1 and allowed by a 0.
// [R03] An allowed request is raised just after SCL falls on the R/W bit.
// [R04] Writing 1 to general call clear wipes that status, then self-clears.
// [R05] The master drives the serial clock only while its clock enable is 1.
// [R06] Loopback feeds the block's own drive to its receive side.
// [R07] Bits 13, 12 and 10 of the configuration read zero and ignore writes.
// [R08] The master channel runs only while the master enable bit is 1.
// [R09] The slave channel watches addresses only while slave enable is 1.
// [R10] With stop interrupt enabled, a stop after start and match interrupts.
module i2ccb_config
  import i2ccb_pkg::*;
(
  input  wire logic                        clk,     // Core clock
  input  wire logic                        nrst,    // Async reset, low
  input  wire i2ccb_pkg::i2ccb_apb_req_type apbReq,  // APB request
  output      i2ccb_pkg::i2ccb_apb_rsp_type apbRsp,  // APB response
  input  wire logic                        sclIn,   // SCL pin level
  output      logic                        sclOut,  // SCL drive value
  output      logic                        sclOe,   // SCL drive enable
  input  wire logic                        sdaIn,   // SDA pin level
  output      logic                        irq      // Interrupt level
);
  import i2ccb_pkg::*;

  i2ccb_state_type st_reg;
  i2ccb_state_type st_next;
  logic            sclLine;
  logic            sdaLine;
  logic            sclRise;
  logic            sclFall;
  logic            startDet;
  logic            stopDet;
  logic            wrHit;
  logic            rdCyc;
  logic [15:0]     wcfg;
  logic [2:0]      setEv;

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.sclSync = {st_reg.sclSync[1:0], sclIn};
    st_next.sdaSync = {st_reg.sdaSync[1:0], sdaIn};
    if (st_reg.sclSync[1] == st_reg.sclSync[2])
    begin
      st_next.sclF = st_reg.sclSync[2];
    end
    if (st_reg.sdaSync[1] == st_reg.sdaSync[2])
    begin
      st_next.sdaF = st_reg.sdaSync[2];
    end
    if (st_reg.cfg[`I2CCB_CFG_LOOP])
    begin
      sclLine = ~st_reg.sclOe; // R06
      sdaLine = 1'b1; // R06
    end
    else
    begin
      sclLine = st_next.sclF;
      sdaLine = st_next.sdaF;
    end
    sclRise  = sclLine & ~st_reg.sclF;
    sclFall  = ~sclLine & st_reg.sclF;
    startDet = sclLine & st_reg.sclF & ~sdaLine & st_reg.sdaF;
    stopDet  = sclLine & st_reg.sclF & sdaLine & ~st_reg.sdaF;
    st_next.sclF = sclLine;
    st_next.sdaF = sdaLine;
    setEv = 3'h0;

    if (!st_reg.cfg[`I2CCB_CFG_SLVEN])
    begin
      st_next.phase   = I2CCB_IDLE; // R09
      st_next.matched = 1'b0;
    end
    else if (startDet)
    begin
      st_next.phase   = I2CCB_ADDR;
      st_next.bitCnt  = 4'h0;
      st_next.matched = 1'b0;
    end
    else if (stopDet)
    begin
      setEv[`I2CCB_ST_STOP] = st_reg.matched &
                              st_reg.cfg[`I2CCB_CFG_STOPIE]; // R10
      st_next.phase   = I2CCB_IDLE;
      st_next.matched = 1'b0;
    end
    else
    begin
      unique case (st_reg.phase)
        I2CCB_IDLE:
        begin
          st_next.bitCnt = 4'h0;
        end
        I2CCB_ADDR:
        begin
          if (sclRise)
          begin
            st_next.shift  = {st_reg.shift[6:0], sdaLine};
            st_next.bitCnt = st_reg.bitCnt + 4'h1;
          end
          if (sclFall && st_reg.bitCnt == 4'h8)
          begin
            st_next.phase  = I2CCB_DATA;
            st_next.bitCnt = 4'h0;
            if (st_reg.shift[7:1] == st_reg.sadr) // R09
            begin
              st_next.matched = 1'b1;
              setEv[`I2CCB_ST_TXREQ] = st_reg.shift[0] &
                ~st_reg.cfg[`I2CCB_CFG_TXRQDIS]; // R02 R03
            end
            else if (st_reg.shift[7:1] == `I2CCB_GCALL_ADR)
            begin
              st_next.matched = 1'b1;
              setEv[`I2CCB_ST_GCALL] = 1'b1;
            end
          end
        end
        I2CCB_DATA:
        begin
          st_next.bitCnt = 4'h0;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Serial clock drive
    // ----------------------------------------------------------------
    if (st_reg.cfg[`I2CCB_CFG_MSTEN] && st_reg.cfg[`I2CCB_CFG_MCLKEN])
    begin
      if (st_reg.divCnt == 8'(`I2CCB_SCL_HALF_CYC - 1)) // R05
      begin
        st_next.divCnt = 8'h00;
        st_next.sclGen = ~st_reg.sclGen;
      end
      else
      begin
        st_next.divCnt = st_reg.divCnt + 8'h01;
      end
    end
    else
    begin
      st_next.divCnt = 8'h00; // R05 R08
      st_next.sclGen = 1'b1;
    end
    st_next.sclOe = st_reg.cfg[`I2CCB_CFG_STRETCH] | ~st_next.sclGen; // R01

    // ----------------------------------------------------------------
    // APB slave, one wait state
    // ----------------------------------------------------------------
    rdCyc = apbReq.psel & apbReq.penable & ~st_reg.rsp.pready;
    wrHit = apbReq.psel & apbReq.penable & st_reg.rsp.pready &
            apbReq.pwrite;
    wcfg  = (apbReq.pwdata[15:0] & `I2CCB_CFG_WMASK) |
            (st_reg.cfg & ~`I2CCB_CFG_WMASK); // R07
    st_next.rsp.pready = rdCyc;
    if (rdCyc)
    begin
      st_next.rsp.pslverr = 1'b0;
      st_next.rsp.prdata  = 32'h0;
      unique case (apbReq.paddr)
        `I2CCB_OFS_CFG:  st_next.rsp.prdata = {16'h0, st_reg.cfg};
        `I2CCB_OFS_STAT: st_next.rsp.prdata = {29'h0, st_reg.stat};
        `I2CCB_OFS_IEN:  st_next.rsp.prdata = {29'h0, st_reg.ien};
        `I2CCB_OFS_ICLR: st_next.rsp.prdata = 32'h0;
        `I2CCB_OFS_SADR: st_next.rsp.prdata = {25'h0, st_reg.sadr};
        default:         st_next.rsp.pslverr = 1'b1;
      endcase
    end

    // General call clear is one cycle, then drops
    if (st_reg.cfg[`I2CCB_CFG_GCCLR])
    begin
      st_next.stat[`I2CCB_ST_GCALL] = 1'b0; // R04
      st_next.cfg[`I2CCB_CFG_GCCLR] = 1'b0; // R04
    end
    if (wrHit)
    begin
      unique case (apbReq.paddr)
        `I2CCB_OFS_CFG:  st_next.cfg  = wcfg; // R07
        `I2CCB_OFS_IEN:  st_next.ien  = apbReq.pwdata[2:0];
        `I2CCB_OFS_ICLR: st_next.stat = st_next.stat & ~apbReq.pwdata[2:0];
        `I2CCB_OFS_SADR: st_next.sadr = apbReq.pwdata[6:0];
        default:         st_next.sadr = st_reg.sadr;
      endcase
    end
    st_next.stat = st_next.stat | setEv;
    st_next.irq  = |(st_next.stat & st_next.ien);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg        <= '0;
      st_reg.sclSync <= 3'h7;
      st_reg.sdaSync <= 3'h7;
      st_reg.sclF   <= 1'b1;
      st_reg.sdaF   <= 1'b1;
      st_reg.sclGen <= 1'b1;
      st_reg.phase  <= I2CCB_IDLE;
      st_reg.cfg    <= `I2CCB_CFG_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign apbRsp = st_reg.rsp;
  assign sclOut = 1'b0;
  assign sclOe  = st_reg.sclOe;
  assign irq    = st_reg.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  stretch_hold_a: assert property ( // R01
    st_reg.cfg[`I2CCB_CFG_STRETCH] |=> sclOe)
    else $error("SCL not held during stretch");
  txreq_mask_a: assert property ( // R02
    st_reg.cfg[`I2CCB_CFG_TXRQDIS] && !st_reg.stat[`I2CCB_ST_TXREQ]
    |=> !st_reg.stat[`I2CCB_ST_TXREQ])
    else $error("Request set while disabled");
  txreq_edge_a: assert property ( // R03
    $rose(st_reg.stat[`I2CCB_ST_TXREQ]) |->
    $past(st_reg.phase) == I2CCB_ADDR && st_reg.phase == I2CCB_DATA)
    else $error("Request not at R/W falling edge");
  gcclr_self_a: assert property ( // R04
    st_reg.cfg[`I2CCB_CFG_GCCLR] |=> !st_reg.cfg[`I2CCB_CFG_GCCLR])
    else $error("General call clear stuck");
  mclk_off_a: assert property ( // R05
    !st_reg.cfg[`I2CCB_CFG_MCLKEN] && !st_reg.cfg[`I2CCB_CFG_STRETCH]
    ##1 !st_reg.cfg[`I2CCB_CFG_STRETCH] |-> !sclOe)
    else $error("Clock driven while disabled");
  mst_off_a: assert property ( // R08
    !st_reg.cfg[`I2CCB_CFG_MSTEN] |=> st_reg.divCnt == 8'h00)
    else $error("Master ran while disabled");
  slv_off_a: assert property ( // R09
    !st_reg.cfg[`I2CCB_CFG_SLVEN] |=> st_reg.phase == I2CCB_IDLE)
    else $error("Slave active while disabled");
  rsvd_zero_a: assert property ( // R07
    st_reg.cfg[13] == 1'b0 && st_reg.cfg[12] == 1'b0 &&
    st_reg.cfg[10] == 1'b0)
    else $error("Reserved bits set");
  stop_irq_a: assert property ( // R10
    $rose(st_reg.stat[`I2CCB_ST_STOP]) |->
    $past(st_reg.cfg[`I2CCB_CFG_STOPIE]) && $past(st_reg.matched))
    else $error("Stop flag without cause");
  loop_scl_a: assert property ( // R06
    st_reg.cfg[`I2CCB_CFG_LOOP] && $past(st_reg.cfg[`I2CCB_CFG_LOOP])
    |-> st_reg.sclF == ~$past(st_reg.sclOe))
    else $error("Loopback not routed");

  txreq_c: cover property ($rose(st_reg.stat[`I2CCB_ST_TXREQ]));
  stop_c:  cover property ($rose(st_reg.stat[`I2CCB_ST_STOP]));
  gcall_c: cover property ($rose(st_reg.stat[`I2CCB_ST_GCALL]));
  irq_c:   cover property ($rose(irq));
endmodule : i2ccb_config

// file: i2ccb_map.svh
// Purpose: Offsets, fields, reset values and counts of the config block
// Assumes: APB byte addressing, 32-bit data
// Notes:   Definitions only
`ifndef I2CCB_MAP_SVH
`define I2CCB_MAP_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define I2CCB_OFS_CFG   8'h00
`define I2CCB_OFS_STAT  8'h04
`define I2CCB_OFS_IEN   8'h08
`define I2CCB_OFS_ICLR  8'h0c
`define I2CCB_OFS_SADR  8'h10
// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define I2CCB_CFG_SLVEN   0
`define I2CCB_CFG_MSTEN   1
`define I2CCB_CFG_LOOP    6
`define I2CCB_CFG_MCLKEN  7
`define I2CCB_CFG_GCCLR   8
`define I2CCB_CFG_TXRQDIS 9
`define I2CCB_CFG_STRETCH 11
`define I2CCB_CFG_STOPIE  14
`define I2CCB_CFG_WMASK   16'h4bfb
`define I2CCB_CFG_RESET   16'h0000
// ----------------------------------------------------------------
// Interrupt status fields
// ----------------------------------------------------------------
`define I2CCB_ST_TXREQ  0
`define I2CCB_ST_STOP   1
`define I2CCB_ST_GCALL  2
`define I2CCB_GCALL_ADR 7'h00
// ----------------------------------------------------------------
// Timing: serial clock half period in ns at 8 ns core clock
// ----------------------------------------------------------------
`define I2CCB_SCL_HALF_NS 1250
`define I2CCB_CLK_NS      8
`define I2CCB_SCL_HALF_CYC (`I2CCB_SCL_HALF_NS / `I2CCB_CLK_NS)
`endif

// file: i2ccb_peer.sv
// Purpose: Behavioural I2C bus master on the serial pins
// Assumes: Both lines pulled up; a 1 releases the line
// Notes:   SCL period 125 ns, still between frames
`timescale 1ns/1ps
module i2ccb_peer
(
  output logic sclDrv, // SCL drive, 0 pulls low
  output logic sdaDrv  // SDA drive, 0 pulls low
);
  initial
  begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  task start;
    sdaDrv = 1'b0;
    #31.25 sclDrv = 1'b0;
  endtask : start
  task sendByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      #31.25 sdaDrv = b[i];
      #31.25 sclDrv = 1'b1;
      #62.5 sclDrv = 1'b0;
    end
  endtask : sendByte
  task ackStop;
    #31.25 sdaDrv = 1'b1;
    #31.25 sclDrv = 1'b1;
    #62.5 sclDrv = 1'b0;
    #31.25 sdaDrv = 1'b0;
    #31.25 sclDrv = 1'b1;
    #31.25 sdaDrv = 1'b1;
  endtask : ackStop
endmodule : i2ccb_peer

// file: i2ccb_pkg.sv
// Purpose: Types of the config block
// Assumes: Constants come from i2ccb_map.svh
// Notes:   One-hot slave phase
package i2ccb_pkg;
  typedef enum logic [2:0] {
    I2CCB_IDLE = 3'h1,
    I2CCB_ADDR = 3'h2,
    I2CCB_DATA = 3'h4
  } i2ccb_phase_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } i2ccb_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } i2ccb_apb_rsp_type;

  typedef struct packed {
    logic [2:0]      sclSync;
    logic [2:0]      sdaSync;
    logic            sclF;
    logic            sdaF;
    i2ccb_phase_type phase;
    logic [3:0]      bitCnt;
    logic [7:0]      shift;
    logic            matched;
    logic [15:0]     cfg;
    logic [2:0]      stat;
    logic [2:0]      ien;
    logic [6:0]      sadr;
    logic [7:0]      divCnt;
    logic            sclGen;
    logic            sclOe;
    logic            irq;
    i2ccb_apb_rsp_type rsp;
  } i2ccb_state_type;
endpackage : i2ccb_pkg

// file: testbench.sv
// Purpose: Self-checking bench of the I2C config block
// Assumes: APB slave answers in its own time
// Notes:   Random values from xorshift seeded with 84
`timescale 1ns/1ps
`include "i2ccb_map.svh"
module testbench;
  import i2ccb_pkg::*;
  logic              clk;
  logic              nrst;
  i2ccb_apb_req_type req;
  i2ccb_apb_rsp_type rsp;
  logic              sclOut;
  logic              sclOe;
  logic              irq;
  logic              sclPeer;
  logic              sdaPeer;
  logic              sclLine;
  logic [31:0]       seed;
  logic [31:0]       rd;
  logic              err;
  int                n_errors;
  int                n_checks;
  logic [15:0]       tabCfg [5] = '{16'h4001, 16'h4201, 16'h0001,
                                    16'h4000, 16'h4041};
  logic [3:0]        tabExp [5] = '{4'hb, 4'h2, 4'h9, 4'h0, 4'h0};
  logic [15:0]       genCfg [5] = '{16'h82, 16'h80, 16'h02, 16'h800, 0};
  logic [1:0]        genExp [5] = '{2'd1, 2'd0, 2'd0, 2'd2, 2'd0};
  assign sclLine = sclPeer & ~(sclOe & ~sclOut);
  i2ccb_config i_i2ccb_config (.clk(clk), .nrst(nrst), .apbReq(req),
    .apbRsp(rsp), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaPeer), .irq(irq));
  i2ccb_peer peer (.sclDrv(sclPeer), .sdaDrv(sdaPeer));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] cfgExp(input logic [31:0] w);
    return w & 32'h4ac3;
  endfunction : cfgExp
  task conclude;
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (rsp.pready !== 1'b1 && k < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1)
    begin
      n_errors++;
      conclude();
    end
    @(posedge clk);
  endtask : apb
  task xfer(input logic [7:0] b, input logic mid, input logic [2:0] fin);
    peer.start();
    peer.sendByte(b);
    repeat (8) @(posedge clk);
    apb(0, `I2CCB_OFS_STAT, 0);
    chk(rd[0], mid);
    peer.ackStop();
    repeat (8) @(posedge clk);
    apb(0, `I2CCB_OFS_STAT, 0);
    chk(rd[2:0], fin);
    chk(irq, |fin);
    apb(1, `I2CCB_OFS_IEN, 0);
    @(posedge clk);
    chk(irq, 0);
    apb(1, `I2CCB_OFS_IEN, 7);
  endtask : xfer
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    int cnt;
    logic [31:0] wd;
    logic [6:0] adr;
    nrst = 1'b0;
    req = '0;
    seed = 32'd84;
    n_errors = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 16; i += 4)
    begin
      apb(0, i[7:0], 0);
      chk(rd, 0);
    end
    apb(0, 8'h40, 0);
    chk({31'h0, err}, 32'h00000001);
    chk(rd, 32'h00000000);
    for (int k = 0; k < 6; k++)
    begin
      wd = (k == 0) ? 32'hffffffff : rnd();
      apb(1, `I2CCB_OFS_CFG, wd);
      apb(0, `I2CCB_OFS_CFG, 0);
      chk(rd & 32'hffff7fc3, cfgExp(wd));
    end
    $display("Test registers done");
    for (int i = 0; i < 5; i++)
    begin
      apb(1, `I2CCB_OFS_CFG, genCfg[i]);
      repeat (4) @(posedge clk);
      cnt = 0;
      repeat (400) @(posedge clk) cnt += sclOe;
      chk((cnt == 0) ? 0 : (cnt == 400) ? 2 : 1, genExp[i]);
      chk({31'h0, sclOut}, 32'h00000000);
    end
    $display("Test serial clock done");
    adr = 7'(rnd() % 126 + 1);
    apb(1, `I2CCB_OFS_SADR, adr);
    apb(0, `I2CCB_OFS_SADR, 0);
    chk(rd, {25'h0, adr});
    apb(1, `I2CCB_OFS_IEN, 7);
    for (int i = 0; i < 5; i++)
    begin
      apb(1, `I2CCB_OFS_CFG, tabCfg[i]);
      xfer({adr, 1'b1}, tabExp[i][3], tabExp[i][2:0]);
      apb(1, `I2CCB_OFS_ICLR, 7);
      apb(0, `I2CCB_OFS_STAT, 0);
      chk(rd, 0);
    end
    $display("Test slave read done");
    apb(1, `I2CCB_OFS_CFG, 1);
    xfer(8'h00, 0, 3'b100);
    apb(1, `I2CCB_OFS_CFG, 32'h101);
    apb(0, `I2CCB_OFS_STAT, 0);
    chk(rd, 0);
    apb(0, `I2CCB_OFS_CFG, 0);
    chk(rd, 1);
    $display("Test general call done");
    conclude();
  end
endmodule : testbench
